// file: rtl/uocr_device.sv
//
// Behaviour
// - Zero rate field selects automatic detection
// - Nonzero N accepts only N times 8 kHz
// - Chooser codes: composite, 8k, 2k, low
// - Six two-bit choosers for outputs three-eight
// - Polarity bit one normal, zero swaps pair
// - Status bit 0 reports good checksum
// - Status bit 1 ready 3 ms after reset
// - Status bit 2 reports full image loaded
// - Host writes image one byte per write
// - Byte port reads back last written byte
// - Thirteen-bit read-only accepted byte tally
// - Host writes 0x51, 0x52, 0x53 back to back
// - No image bytes before unlock completes
// - Host writes rate code three times
// - Third valid rate write fires soft reset
// - Oscillator rate defaults to 12.8 MHz
// - Host waits 50 us before rate writes
// - Bits 7:6 show active rate code
// - Repeat tally one on new code, zero after three
// - Tally in bits 5:4, cleared on interruption
// - Bits 3:0 one-hot pending code tag
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module uocr_device
  import uocr_pkg::*;
#(
  parameter int READY_DELAY = READY_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  uocr_link_if.dev LINK,
  input wire logic COMPOSITE_IN,
  input wire logic EIGHT_KHZ_FRAME_PULSE,
  input wire logic TWO_KHZ_FRAME_PULSE,
  output logic [5:0] FRAME_OUT,
  input wire logic DIFF_REFERENCE_A_P,
  input wire logic DIFF_REFERENCE_B_P,
  output logic DIFF_REFERENCE_A_OUT,
  output logic DIFF_REFERENCE_B_OUT,
  output logic AUTO_DETECT,
  output logic [14:0] ACCEPT_MULTIPLE,
  output logic [1:0] OSC_RATE_CODE,
  output logic SOFT_RESET,
  output logic [7:0] IMAGE_BYTE,
  output logic IMAGE_VALID
);

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic wr, rd, acc;
  logic [7:0] wd;
  assign wr = LINK.reg_wr;
  assign rd = LINK.reg_rd;
  assign acc = wr | rd;
  assign wd = LINK.reg_wdata;

  logic [14:0] acc_rate_ff;
  logic [11:0] frame_sel_ff;
  logic [7:0] loader_byte_ff, sum_ff, rdata_ff;
  logic [12:0] tally_ff;
  logic [31:0] ready_cnt_ff;
  logic [1:0] diff_inv_ff, unlock_step_ff, frq_ff, rep_cnt_ff;
  logic [3:0] tag_ff;
  logic ready_ff, soft_ff, ack_ff, img_valid_ff;
  logic unlocked, done, byte_take;
  assign unlocked = (unlock_step_ff == 2'd3);
  assign done = (tally_ff == IMAGE_BYTES);
  // Bytes outside the unlocked window are stored but never fed to the image
  assign byte_take = wr && LINK.reg_addr == OFS_LOADER_BYTE && unlocked && !done;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_rate_ff <= RST_ACC_RATE;
      frame_sel_ff <= RST_FRAME;
      diff_inv_ff <= RST_DIFF_INV;
    end else if (wr) begin
      unique case (LINK.reg_addr)
        OFS_ACC_RATE_LO: acc_rate_ff[7:0] <= wd;
        OFS_ACC_RATE_HI: acc_rate_ff[14:8] <= wd[6:0];
        OFS_FRAME_LO: frame_sel_ff[7:0] <= wd;
        OFS_FRAME_HI: frame_sel_ff[11:8] <= wd[3:0];
        OFS_DIFF_INV: diff_inv_ff <= wd[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Ready timer
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ready_cnt_ff <= 32'h0;
      ready_ff <= 1'b0;
    end else if (!ready_ff) begin
      ready_cnt_ff <= ready_cnt_ff + 32'h1;
      ready_ff <= ready_cnt_ff >= 32'(READY_DELAY - 1);
    end
  end

  // ----------------------------------------
  // Unlock sequence
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      unlock_step_ff <= 2'd0;
    end else if (acc && !unlocked) begin
      if (wr && LINK.reg_addr == OFS_LOADER_UNLOCK && ready_ff) begin
        if (unlock_step_ff == 2'd0 && wd == UNLOCK_FIRST) begin
          unlock_step_ff <= 2'd1;
        end else if (unlock_step_ff == 2'd1 && wd == UNLOCK_SECOND) begin
          unlock_step_ff <= 2'd2;
        end else if (unlock_step_ff == 2'd2 && wd == UNLOCK_THIRD) begin
          unlock_step_ff <= 2'd3;
        end else begin
          unlock_step_ff <= 2'd0;
        end
      end else begin
        unlock_step_ff <= 2'd0;
      end
    end
  end

  // ----------------------------------------
  // Byte port, tally and checksum
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      loader_byte_ff <= RST_LOADER_BYTE;
    end else if (wr && LINK.reg_addr == OFS_LOADER_BYTE) begin
      loader_byte_ff <= wd;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tally_ff <= 13'h0;
      sum_ff <= 8'h00;
      img_valid_ff <= 1'b0;
      IMAGE_BYTE <= 8'h00;
    end else begin
      img_valid_ff <= byte_take;
      if (byte_take) begin
        tally_ff <= tally_ff + 13'h1;
        sum_ff <= sum_ff + wd;
        IMAGE_BYTE <= wd;
      end
    end
  end

  // ----------------------------------------
  // Oscillator rate select
  // ----------------------------------------
  logic osc_wr, osc_valid;
  assign osc_wr = wr && LINK.reg_addr == OFS_OSC_RATE;
  assign osc_valid = wd == OSC_CODE_10M || wd == OSC_CODE_12M8 ||
                     wd == OSC_CODE_19M2 || wd == OSC_CODE_20M;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      frq_ff <= RST_OSC_RATE_CODE;
      rep_cnt_ff <= 2'd0;
      tag_ff <= 4'h0;
      soft_ff <= 1'b0;
    end else begin
      soft_ff <= 1'b0;
      if (osc_wr) begin
        if (!osc_valid) begin
          rep_cnt_ff <= 2'd0;
          tag_ff <= 4'h0;
        end else if (rep_cnt_ff == 2'd0 || tag_ff != wd[7:4]) begin
          rep_cnt_ff <= 2'd1;
          tag_ff <= wd[7:4];
        end else if (rep_cnt_ff == 2'd2) begin
          rep_cnt_ff <= 2'd0;
          frq_ff <= {wd[7] | wd[6], wd[7] | wd[5]};
          soft_ff <= 1'b1;
        end else begin
          rep_cnt_ff <= rep_cnt_ff + 2'd1;
        end
      end else if (acc && LINK.reg_addr != OFS_OSC_RATE) begin
        // Any other access breaks the triple, which keeps stray traffic from arming it
        rep_cnt_ff <= 2'd0;
        tag_ff <= 4'h0;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    unique case (LINK.reg_addr)
      OFS_ACC_RATE_LO: rmux = acc_rate_ff[7:0];
      OFS_ACC_RATE_HI: rmux = {1'b0, acc_rate_ff[14:8]};
      OFS_FRAME_LO: rmux = frame_sel_ff[7:0];
      OFS_FRAME_HI: rmux = {4'h0, frame_sel_ff[11:8]};
      OFS_DIFF_INV: rmux = {6'h00, diff_inv_ff};
      OFS_LOADER_STATE: begin
        rmux[CHK_POS] = done && sum_ff == 8'h00;
        rmux[READY_POS] = ready_ff;
        rmux[DONE_POS] = done;
      end
      OFS_LOADER_BYTE: rmux = loader_byte_ff;
      OFS_TALLY_LO: rmux = tally_ff[7:0];
      OFS_TALLY_HI: rmux = {3'h0, tally_ff[12:8]};
      OFS_OSC_RATE: rmux = {frq_ff, rep_cnt_ff, tag_ff};
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 8'h00;
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= acc;
      if (rd) begin
        rdata_ff <= rmux;
      end
    end
  end

  // ----------------------------------------
  // Frame chooser and reference polarity
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_frame
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          FRAME_OUT[gi] <= 1'b0;
        end else begin
          unique case (frame_sel_ff[2*gi +: 2])
            2'd0: FRAME_OUT[gi] <= COMPOSITE_IN;
            2'd1: FRAME_OUT[gi] <= EIGHT_KHZ_FRAME_PULSE;
            2'd2: FRAME_OUT[gi] <= TWO_KHZ_FRAME_PULSE;
            2'd3: FRAME_OUT[gi] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DIFF_REFERENCE_A_OUT <= 1'b0;
      DIFF_REFERENCE_B_OUT <= 1'b0;
      AUTO_DETECT <= 1'b1;
      ACCEPT_MULTIPLE <= RST_ACC_RATE;
    end else begin
      DIFF_REFERENCE_A_OUT <= DIFF_REFERENCE_A_P ^ ~diff_inv_ff[0];
      DIFF_REFERENCE_B_OUT <= DIFF_REFERENCE_B_P ^ ~diff_inv_ff[1];
      AUTO_DETECT <= acc_rate_ff == 15'h0000;
      ACCEPT_MULTIPLE <= acc_rate_ff;
    end
  end

  assign LINK.reg_rdata = rdata_ff;
  assign LINK.reg_ack = ack_ff;
  assign OSC_RATE_CODE = frq_ff;
  assign SOFT_RESET = soft_ff;
  assign IMAGE_VALID = img_valid_ff;

endmodule

// file: rtl/uocr_pkg.sv
package uocr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_ACC_RATE_LO = 8'h5B;
  localparam logic [7:0] OFS_ACC_RATE_HI = 8'h5C;
  localparam logic [7:0] OFS_FRAME_LO = 8'h5D;
  localparam logic [7:0] OFS_FRAME_HI = 8'h5E;
  localparam logic [7:0] OFS_DIFF_INV = 8'h5F;
  localparam logic [7:0] OFS_LOADER_STATE = 8'h70;
  localparam logic [7:0] OFS_LOADER_BYTE = 8'h71;
  localparam logic [7:0] OFS_TALLY_LO = 8'h72;
  localparam logic [7:0] OFS_TALLY_HI = 8'h73;
  localparam logic [7:0] OFS_LOADER_UNLOCK = 8'h74;
  localparam logic [7:0] OFS_OSC_RATE = 8'h7F;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [14:0] RST_ACC_RATE = 15'h0000;
  localparam logic [11:0] RST_FRAME = 12'h000;
  localparam logic [1:0] RST_DIFF_INV = 2'h3;
  localparam logic [7:0] RST_LOADER_BYTE = 8'h00;
  localparam logic [1:0] RST_OSC_RATE_CODE = 2'h1;
  localparam int FRQ_POS = 6;
  localparam int CNT_POS = 4;
  localparam int CHK_POS = 0;
  localparam int READY_POS = 1;
  localparam int DONE_POS = 2;

  // ----------------------------------------
  // Loader and oscillator rate constants
  // ----------------------------------------
  localparam logic [12:0] IMAGE_BYTES = 13'h1DB0;
  localparam logic [7:0] UNLOCK_FIRST = 8'h51;
  localparam logic [7:0] UNLOCK_SECOND = 8'h52;
  localparam logic [7:0] UNLOCK_THIRD = 8'h53;
  localparam logic [7:0] OSC_CODE_10M = 8'h11;
  localparam logic [7:0] OSC_CODE_12M8 = 8'h22;
  localparam logic [7:0] OSC_CODE_19M2 = 8'h44;
  localparam logic [7:0] OSC_CODE_20M = 8'h88;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int READY_TIME_US = 3000;
  localparam int READY_CYC = READY_TIME_US * CLK_MHZ;
  localparam int OSC_GUARD_TIME_US = 50;
  localparam int OSC_GUARD_CYC = OSC_GUARD_TIME_US * CLK_MHZ;

  // ----------------------------------------
  // Host command registers (Avalon byte addresses)
  // ----------------------------------------
  localparam logic [3:0] HOST_OFS_CMD = 4'h0;
  localparam logic [3:0] HOST_OFS_STATUS = 4'h4;
  localparam int CMD_WDATA_POS = 8;
  localparam int CMD_WRITE_POS = 16;

  typedef enum logic [1:0] {
    UOCR_LNK_IDLE,
    UOCR_LNK_WAIT
  } uocr_link_e;

endpackage

// file: rtl/uocr_link_if.sv
`timescale 1ns/1ps
interface uocr_link_if;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;

  modport dev (
    input reg_addr, reg_wr, reg_rd, reg_wdata,
    output reg_rdata, reg_ack
  );

  modport host (
    output reg_addr, reg_wr, reg_rd, reg_wdata,
    input reg_rdata, reg_ack
  );
endinterface

// file: rtl/uocr_host.sv
`timescale 1ns/1ps
module uocr_host
  import uocr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  uocr_link_if.host LINK
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  uocr_link_e state_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [7:0] addr_ff;
  logic [7:0] wdata_ff;
  logic wr_ff;
  logic rd_ff;
  logic [7:0] last_rd_ff;
  logic [10:0] guard_ff;
  logic guard_done;
  logic cmd_hit;
  logic can_take;

  assign guard_done = guard_ff == 11'(OSC_GUARD_CYC);
  assign cmd_hit = AVS_WRITE && AVS_ADDRESS == HOST_OFS_CMD;
  // Rate writes are held off until the post-reset settling time has passed
  assign can_take = !cmd_hit || (state_ff == UOCR_LNK_IDLE &&
                    (guard_done || !AVS_WRITEDATA[CMD_WRITE_POS] ||
                     AVS_WRITEDATA[7:0] != OFS_OSC_RATE));

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      guard_ff <= 11'h0;
    end else if (!guard_done) begin
      guard_ff <= guard_ff + 11'h1;
    end
  end

  // ----------------------------------------
  // Avalon slave
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0;
    end else if (!wait_ff) begin
      wait_ff <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && can_take) begin
      wait_ff <= 1'b0;
      if (AVS_READ) begin
        rdata_ff <= (AVS_ADDRESS == HOST_OFS_STATUS) ?
                    {16'h0, last_rd_ff, 7'h0, state_ff != UOCR_LNK_IDLE} : 32'h0;
      end
    end
  end

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= UOCR_LNK_IDLE;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      last_rd_ff <= 8'h00;
    end else begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      unique case (state_ff)
        UOCR_LNK_IDLE: begin
          // Each command is one access, so software owns the order of
          // unlock, image and rate sequences
          if (!wait_ff && cmd_hit) begin
            addr_ff <= AVS_WRITEDATA[7:0];
            wdata_ff <= AVS_WRITEDATA[CMD_WDATA_POS +: 8];
            wr_ff <= AVS_WRITEDATA[CMD_WRITE_POS];
            rd_ff <= !AVS_WRITEDATA[CMD_WRITE_POS];
            state_ff <= UOCR_LNK_WAIT;
          end
        end
        UOCR_LNK_WAIT: begin
          if (LINK.reg_ack) begin
            if (!wr_ff) begin
              last_rd_ff <= LINK.reg_rdata;
            end
            state_ff <= UOCR_LNK_IDLE;
          end
        end
        default: state_ff <= UOCR_LNK_IDLE;
      endcase
    end
  end

  assign AVS_WAITREQUEST = wait_ff;
  assign AVS_READDATA = rdata_ff;
  assign LINK.reg_addr = addr_ff;
  assign LINK.reg_wdata = wdata_ff;
  assign LINK.reg_wr = wr_ff;
  assign LINK.reg_rd = rd_ff;

endmodule

// file: tb/uocr_checker.sv
`timescale 1ns/1ps
module uocr_checker
  import uocr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack
);
  // ----------------------------------------
  // Shadow of the config, byte port and rate registers
  // ----------------------------------------
  localparam logic [7:0] MASK [0:4] = '{8'hFF, 8'h7F, 8'hFF, 8'h0F, 8'h03};
  logic [7:0] cfg_ff [0:4];
  logic [7:0] byte_ff;
  logic [1:0] frq_ff;
  logic [1:0] cnt_ff;
  logic [3:0] tag_ff;
  logic [2:0] idx;
  logic [7:0] cfg_sel;
  logic hit_cfg;
  logic osc_ok;
  assign idx = 3'(reg_addr - OFS_ACC_RATE_LO);
  assign cfg_sel = cfg_ff[idx];
  assign hit_cfg = reg_addr >= OFS_ACC_RATE_LO && reg_addr <= OFS_DIFF_INV;
  assign osc_ok = reg_wdata inside {OSC_CODE_10M, OSC_CODE_12M8, OSC_CODE_19M2, OSC_CODE_20M};
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_ff <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    end else if (reg_wr && hit_cfg) begin
      cfg_ff[idx] <= reg_wdata & MASK[idx];
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      byte_ff <= 8'h00;
    end else if (reg_wr && reg_addr == OFS_LOADER_BYTE) begin
      byte_ff <= reg_wdata;
    end
  end
  // Same code after a finished triple restarts the tally; benches avoid that case
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      frq_ff <= 2'h1;
      cnt_ff <= 2'h0;
      tag_ff <= 4'h0;
    end else if ((reg_wr || reg_rd) && reg_addr != OFS_OSC_RATE || reg_wr && !osc_ok) begin
      cnt_ff <= 2'h0;
      tag_ff <= 4'h0;
    end else if (reg_wr && (tag_ff != reg_wdata[7:4] || cnt_ff == 2'h0)) begin
      cnt_ff <= 2'h1;
      tag_ff <= reg_wdata[7:4];
    end else if (reg_wr && cnt_ff == 2'h2) begin
      cnt_ff <= 2'h0;
      frq_ff <= {tag_ff[3] | tag_ff[2], tag_ff[3] | tag_ff[1]};
    end else if (reg_wr) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  property p_ack_follows;
    (reg_wr || reg_rd) |=> reg_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing");
  property p_ack_cause;
    reg_ack |-> $past(reg_wr) || $past(reg_rd);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_one_kind;
    reg_wr |-> !reg_rd;
  endproperty
  a_one_kind: assert property (p_one_kind) else $error("read and write together");
  property p_wr_pulse;
    reg_wr |=> !reg_wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_byte_back;
    reg_rd && reg_addr == OFS_LOADER_BYTE |=> reg_rdata == byte_ff;
  endproperty
  a_byte_back: assert property (p_byte_back) else $error("byte port readback wrong");
  property p_cfg_back;
    reg_rd && hit_cfg |=> reg_rdata == $past(cfg_sel);
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
  property p_osc_back;
    reg_rd && reg_addr == OFS_OSC_RATE |=> reg_rdata == {frq_ff, cnt_ff, tag_ff};
  endproperty
  a_osc_back: assert property (p_osc_back) else $error("rate readback wrong");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  c_byte: cover property (reg_rd && reg_addr == OFS_LOADER_BYTE);
  c_osc_two: cover property (reg_rd && reg_addr == OFS_OSC_RATE && cnt_ff == 2'h2);
  c_cfg_wr: cover property (reg_wr && hit_cfg);
endmodule

// file: tb/upgrade_and_osc_config_regs_tb_top.sv
`timescale 1ns/1ps
module upgrade_and_osc_config_regs_tb_top
  import uocr_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] frm_src = 3'h0;
  logic [1:0] diff_p = 2'h0;
  logic [5:0] frame_out;
  logic diff_a_out, diff_b_out, auto_detect, soft_reset, image_valid;
  logic [14:0] accept_multiple;
  logic [1:0] osc_code;
  logic [7:0] image_byte;
  int bad_count = 0;
  int total_checks = 0;
  int sr_count = 0;
  int img_count = 0;
  int cyc = 0;
  uocr_link_if link ();
  uocr_device #(.READY_DELAY(20)) u_uocr_device (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(link),
    .COMPOSITE_IN(frm_src[0]), .EIGHT_KHZ_FRAME_PULSE(frm_src[1]),
    .TWO_KHZ_FRAME_PULSE(frm_src[2]), .FRAME_OUT(frame_out), .DIFF_REFERENCE_A_P(diff_p[0]),
    .DIFF_REFERENCE_B_P(diff_p[1]), .DIFF_REFERENCE_A_OUT(diff_a_out),
    .DIFF_REFERENCE_B_OUT(diff_b_out), .AUTO_DETECT(auto_detect),
    .ACCEPT_MULTIPLE(accept_multiple), .OSC_RATE_CODE(osc_code), .SOFT_RESET(soft_reset),
    .IMAGE_BYTE(image_byte), .IMAGE_VALID(image_valid));
  uocr_host u_uocr_host (.REF_CLK(ref_clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .LINK(link));
  uocr_checker u_uocr_checker (.REF_CLK(ref_clk), .RST_N(rst_n), .reg_addr(link.reg_addr),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic av(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
      output logic [31:0] rdv);
    @(posedge ref_clk);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic idle();
    logic [31:0] s;
    do av(1'b0, HOST_OFS_STATUS, 32'h0, s); while (s[0] !== 1'b0);
  endtask
  task automatic dev_wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [31:0] s;
    av(1'b1, HOST_OFS_CMD, {15'h0, 1'b1, d, ofs}, s);
  endtask
  task automatic dev_rd(input logic [7:0] ofs, output logic [7:0] d);
    logic [31:0] s;
    av(1'b1, HOST_OFS_CMD, {24'h0, ofs}, s);
    do av(1'b0, HOST_OFS_STATUS, 32'h0, s); while (s[0] !== 1'b0);
    d = s[15:8];
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally(output logic [31:0] t);
    logic [7:0] lo, hi;
    dev_rd(OFS_TALLY_LO, lo);
    dev_rd(OFS_TALLY_HI, hi);
    t = {16'h0, hi, lo};
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic fsel(input logic [1:0] c, input logic [2:0] s);
    fsel = (c == 2'h3) ? 1'b0 : s[c];
  endfunction
  // ----------------------------------------
  // Clock, monitors, watchdog
  // ----------------------------------------
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (soft_reset === 1'b1) sr_count++;
    if (image_valid === 1'b1) img_count++;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] v, sum;
    logic [31:0] w;
    logic [5:0] e;
    logic [7:0] codes [0:3];
    logic [1:0] frq [0:3];
    int n0;
    codes = '{OSC_CODE_10M, OSC_CODE_20M, OSC_CODE_12M8, OSC_CODE_19M2};
    frq = '{2'h0, 2'h3, 2'h1, 2'h2};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    dev_rd(OFS_LOADER_STATE, v);
    chk("state early", v, 8'h00);
    chk("auto", auto_detect, 1'b1);
    chk("rate code", osc_code, 2'h1);
    dev_rd(OFS_DIFF_INV, v);
    chk("polarity", v, 8'h03);
    dev_rd(OFS_OSC_RATE, v);
    chk("rate reg", v, 8'h40);
    av(1'b0, 4'h8, 32'h0, w);
    chk("unmapped", w, 32'h0);
    do dev_rd(OFS_LOADER_STATE, v); while (v[1] !== 1'b1);
    chk("ready", v, 8'h02);
    $display("reset test done");
    dev_wr(OFS_ACC_RATE_LO, 8'hFF);
    dev_wr(OFS_ACC_RATE_HI, 8'hFF);
    idle();
    chk("multiple", accept_multiple, 15'h7FFF);
    chk("auto off", auto_detect, 1'b0);
    dev_wr(OFS_ACC_RATE_LO, 8'h00);
    dev_wr(OFS_ACC_RATE_HI, 8'h00);
    dev_wr(OFS_FRAME_LO, 8'hE4);
    dev_wr(OFS_FRAME_HI, 8'h09);
    dev_wr(OFS_DIFF_INV, 8'h01);
    idle();
    chk("auto on", auto_detect, 1'b1);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      frm_src <= i[2:0];
      diff_p <= i[1:0];
      repeat (3) @(posedge ref_clk);
      for (int j = 0; j < 6; j++) e[j] = fsel(2'(12'h9E4 >> (2 * j)), i[2:0]);
      chk("frame", frame_out, e);
      chk("diff", {diff_b_out, diff_a_out}, {~i[1], i[0]});
    end
    $display("config test done");
    dev_wr(OFS_LOADER_BYTE, 8'hA5);
    dev_rd(OFS_LOADER_BYTE, v);
    chk("byte port", v, 8'hA5);
    dev_wr(OFS_LOADER_UNLOCK, UNLOCK_FIRST);
    dev_wr(OFS_LOADER_UNLOCK, UNLOCK_SECOND);
    dev_rd(OFS_TALLY_LO, v);
    dev_wr(OFS_LOADER_UNLOCK, UNLOCK_THIRD);
    dev_wr(OFS_LOADER_UNLOCK, UNLOCK_FIRST);
    dev_wr(OFS_LOADER_UNLOCK, UNLOCK_THIRD);
    dev_wr(OFS_LOADER_BYTE, 8'h11);
    tally(w);
    chk("locked tally", w, 32'h0);
    dev_wr(OFS_LOADER_UNLOCK, UNLOCK_FIRST);
    dev_wr(OFS_LOADER_UNLOCK, UNLOCK_SECOND);
    dev_wr(OFS_LOADER_UNLOCK, UNLOCK_THIRD);
    sum = 8'h00;
    for (int i = 0; i < 7599; i++) begin
      dev_wr(OFS_LOADER_BYTE, i[7:0]);
      sum = sum + i[7:0];
    end
    tally(w);
    chk("tally", w, 32'd7599);
    dev_rd(OFS_LOADER_STATE, v);
    chk("incomplete", v, 8'h02);
    dev_wr(OFS_LOADER_BYTE, 8'h00 - sum);
    dev_wr(OFS_LOADER_BYTE, 8'h3C);
    tally(w);
    chk("full tally", w, {19'h0, IMAGE_BYTES});
    dev_rd(OFS_LOADER_STATE, v);
    chk("complete", v, 8'h07);
    dev_rd(OFS_LOADER_BYTE, v);
    chk("last byte", v, 8'h3C);
    chk("accepted", img_count, 32'd7600);
    chk("image byte", image_byte, 8'(8'h00 - sum));
    $display("loader test done");
    dev_wr(OFS_OSC_RATE, OSC_CODE_19M2);
    dev_rd(OFS_OSC_RATE, v);
    chk("rate once", v, 8'h54);
    dev_wr(OFS_OSC_RATE, OSC_CODE_19M2);
    dev_rd(OFS_OSC_RATE, v);
    chk("rate twice", v, 8'h64);
    dev_rd(OFS_LOADER_STATE, v);
    dev_rd(OFS_OSC_RATE, v);
    chk("rate broken", v, 8'h40);
    dev_wr(OFS_OSC_RATE, 8'h33);
    dev_rd(OFS_OSC_RATE, v);
    chk("rate invalid", v, 8'h40);
    for (int k = 0; k < 4; k++) begin
      n0 = sr_count;
      repeat (3) dev_wr(OFS_OSC_RATE, codes[k]);
      dev_rd(OFS_OSC_RATE, v);
      chk("rate done", v, {frq[k], 2'h0, codes[k][7:4]});
      chk("rate port", osc_code, frq[k]);
      chk("soft reset", sr_count - n0, 32'd1);
    end
    $display("rate test done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk("rate in reset", osc_code, 2'h1);
    rst_n <= 1'b1;
    n0 = cyc;
    dev_rd(OFS_OSC_RATE, v);
    chk("rate after reset", v, 8'h40);
    tally(w);
    chk("tally after reset", w, 32'h0);
    dev_wr(OFS_OSC_RATE, OSC_CODE_20M);
    chk("rate guard", cyc - n0 >= OSC_GUARD_CYC, 1'b1);
    $display("second reset test done");
    stop_test();
  end
endmodule
